// ==== verilog/adcseq_pkg.sv ====
// =====================================================================
// Shared constants and types of the auto sampling sequencer
package adcseq_pkg;

  // =====================================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 12;               // Byte address width
  localparam int unsigned DATA_W = 32;               // Avalon data width
  localparam int unsigned IDX_W = 10;                // Word index width

  // =====================================================================
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_VREF_SELECT = 10'h0E7;
  localparam logic [IDX_W-1:0] IDX_RESOLUTION_SELECT = 10'h0EB;
  localparam logic [IDX_W-1:0] IDX_DIFF_MISC_RES = 10'h0EC;
  localparam logic [IDX_W-1:0] IDX_SAMPLE_TIME_LR = 10'h0ED;
  localparam logic [IDX_W-1:0] IDX_SAMPLE_TIME_MISC = 10'h0EE;
  localparam logic [IDX_W-1:0] IDX_MISC_CAP_LEN_LOW = 10'h0EF;
  localparam logic [IDX_W-1:0] IDX_LR_CAP_LEN_LOW = 10'h0F0;
  localparam logic [IDX_W-1:0] IDX_STATE_LEN_HIGH = 10'h0F1;
  localparam logic [IDX_W-1:0] IDX_CHAN_EN_LAST = 10'h0F2;
  localparam logic [IDX_W-1:0] IDX_CONV_CLK_DIV = 10'h0F4;
  localparam logic [IDX_W-1:0] IDX_MISC_RESULT_LOW = 10'h0F7;
  localparam logic [IDX_W-1:0] IDX_MISC_RESULT_HIGH = 10'h0F8;
  localparam logic [IDX_W-1:0] IDX_INPUT_SCALING = 10'h0FA;
  localparam logic [IDX_W-1:0] IDX_CONVERTER_POWER = 10'h0FC;

  // =====================================================================
  // Field positions
  localparam int unsigned POWER_DOWN_BIT = 5;        // converter_power_down
  localparam int unsigned VALID_BIT = 7;             // result_valid_flag
  localparam int unsigned DIFF_BIT_BASE = 4;         // Left diff at 4, right 5, misc 6
  localparam int unsigned SCALE_LSB = 6;             // input_scaling_select
  localparam int unsigned LAST_IDX_LSB = 4;          // Last state index field
  localparam int unsigned EN_LEFT_BIT = 0;
  localparam int unsigned EN_RIGHT_BIT = 1;
  localparam int unsigned EN_MISC_BIT = 2;
  localparam int unsigned RES_RIGHT_LSB = 4;         // Right resolution in 0xeb
  localparam int unsigned TSAMP_RIGHT_LSB = 4;       // Right sampling time in 0xed
  localparam int unsigned SET_LEN_LSB = 0;           // Set length in 0xf1
  localparam int unsigned LR_CAP_HI_LSB = 4;         // Left/right capture high bits
  localparam int unsigned MISC_CAP_HI_LSB = 6;       // aux_capture_length high bits

  // =====================================================================
  // Reset values
  localparam logic [7:0] POWER_RST = 8'h20;          // Powered down out of reset
  localparam logic [7:0] REG_RST = 8'h00;            // All other settings

  // Resolution codes
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [1:0] RES_14 = 2'h3;

  // =====================================================================
  // Timing: reference rate and system clock rate in kHz
  localparam int unsigned REF_KHZ = 24000;
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned RATE_GCD = 1000;
  localparam logic [7:0] REF_STEP = 8'(REF_KHZ / RATE_GCD);  // Phase step per clk
  localparam logic [7:0] REF_MOD = 8'(CLK_KHZ / RATE_GCD);   // Phase modulus

  // =====================================================================
  // Enumerations
  typedef enum logic [1:0] {CH_LEFT, CH_RIGHT, CH_MISC} adcseq_chan_e_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_SET, SQ_CAPTURE} adcseq_seq_e_t;

  // =====================================================================
  // Carriers
  typedef struct packed {
    logic power_down;           // converter_power_down level
    logic clk_en;               // Converter clock enable pulse
    logic run;                  // Start of conversion pulse
    adcseq_chan_e_t chan;       // Channel for the input mux
    logic [1:0] vref;           // Reference select
    logic [1:0] res;            // Resolution code
    logic diff;                 // Differential input
    logic [3:0] tsamp;          // Sampling time in converter clocks
    logic [1:0] scale;          // input_scaling_select
  } adcseq_conv_ctrl_t;

  typedef struct packed {
    logic valid;                // One-cycle result strobe
    adcseq_chan_e_t chan;       // Source channel
    logic [14:0] data;          // Sign-extended result
  } adcseq_sample_t;

  typedef struct packed {
    logic [7:0] vref_select;
    logic [7:0] resolution_select;
    logic [7:0] diff_and_misc_resolution;
    logic [7:0] sample_time_lr;
    logic [7:0] sample_time_misc;
    logic [7:0] misc_capture_len_low;
    logic [7:0] lr_capture_len_low;
    logic [7:0] state_length_high;
    logic [7:0] channel_enable_last_index;
    logic [7:0] converter_clock_divider;
    logic [7:0] input_scaling;
    logic [7:0] converter_power;
  } adcseq_regs_t;

  typedef struct packed {
    adcseq_regs_t regs;         // Software settings
    adcseq_seq_e_t st;          // Sequencer phase
    logic [2:0] idx;            // Current state index
    adcseq_chan_e_t chan;       // Current channel
    logic [9:0] cnt;            // Reference ticks spent in state
    logic [7:0] ref_acc;        // Reference phase accumulator
    logic [2:0] div_cnt;        // Converter clock divider
    logic [14:0] result_misc;   // Latest misc result
    logic valid_flag;           // result_valid_flag
    adcseq_conv_ctrl_t ctrl;    // Converter control outputs
    adcseq_sample_t sample;     // Result stream output
    logic ack;                  // Bus answer cycle
    logic [DATA_W-1:0] rdata;   // Bus read data
  } adcseq_state_t;

endpackage

// ==== verilog/adcseq_sequencer.sv ====
`timescale 1ns/10ps
module adcseq_sequencer (
  input wire logic clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [adcseq_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [adcseq_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [adcseq_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Converter core, same clock domain
  input wire logic [13:0] conv_data_i,
  output adcseq_pkg::adcseq_conv_ctrl_t conv_ctrl_o,
  // Result stream
  output adcseq_pkg::adcseq_sample_t sample_o
);

  // =====================================================================
  // Helper functions

  // Channel of the n-th enabled slot; bit 2 says whether it exists
  function automatic logic [2:0] slot_chan(input logic [1:0] slot, input logic [2:0] en);
    logic [1:0] seen;
    logic [2:0] res;
    seen = 2'h0;
    res = 3'h0;
    for (int c = 0; c < 3; c++) begin
      if (en[c] && !res[2]) begin
        if (seen == slot) begin
          res = {1'b1, 2'(c)};
        end
        seen = seen + 2'h1;
      end
    end
    return res;
  endfunction

  // Sign-extend a raw result of the chosen resolution to 15 bits
  function automatic logic [14:0] sext(input logic [13:0] raw, input logic [1:0] res);
    logic [14:0] v;
    v = {1'b0, raw};
    unique case (res)
      adcseq_pkg::RES_8: v = {{7{raw[7]}}, raw[7:0]};
      adcseq_pkg::RES_10: v = {{5{raw[9]}}, raw[9:0]};
      adcseq_pkg::RES_12: v = {{3{raw[11]}}, raw[11:0]};
      adcseq_pkg::RES_14: v = {raw[13], raw};
    endcase
    return v;
  endfunction

  // Settings applied to the converter for one channel
  function automatic adcseq_pkg::adcseq_conv_ctrl_t chan_settings(
    input adcseq_pkg::adcseq_regs_t r,
    input adcseq_pkg::adcseq_chan_e_t ch
  );
    adcseq_pkg::adcseq_conv_ctrl_t s;
    s = '0;
    s.power_down = r.converter_power[adcseq_pkg::POWER_DOWN_BIT];
    s.chan = ch;
    s.scale = r.input_scaling[adcseq_pkg::SCALE_LSB +: 2];
    unique case (ch)
      adcseq_pkg::CH_LEFT: begin
        s.vref = r.vref_select[1:0];
        s.res = r.resolution_select[1:0];
        s.diff = r.diff_and_misc_resolution[adcseq_pkg::DIFF_BIT_BASE];
        s.tsamp = r.sample_time_lr[3:0];
      end
      adcseq_pkg::CH_RIGHT: begin
        s.vref = r.vref_select[3:2];
        s.res = r.resolution_select[adcseq_pkg::RES_RIGHT_LSB +: 2];
        s.diff = r.diff_and_misc_resolution[adcseq_pkg::DIFF_BIT_BASE + 1];
        s.tsamp = r.sample_time_lr[adcseq_pkg::TSAMP_RIGHT_LSB +: 4];
      end
      default: begin
        // Misc channel; code 3 never occurs but falls here too
        s.vref = r.vref_select[5:4];
        s.res = r.diff_and_misc_resolution[1:0];
        s.diff = r.diff_and_misc_resolution[adcseq_pkg::DIFF_BIT_BASE + 2];
        s.tsamp = r.sample_time_misc[3:0];
      end
    endcase
    return s;
  endfunction

  // Read multiplexer; unmapped words read as zero
  function automatic logic [7:0] read_reg(
    input logic [adcseq_pkg::IDX_W-1:0] idx,
    input adcseq_pkg::adcseq_state_t s
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      adcseq_pkg::IDX_VREF_SELECT: v = s.regs.vref_select;
      adcseq_pkg::IDX_RESOLUTION_SELECT: v = s.regs.resolution_select;
      adcseq_pkg::IDX_DIFF_MISC_RES: v = s.regs.diff_and_misc_resolution;
      adcseq_pkg::IDX_SAMPLE_TIME_LR: v = s.regs.sample_time_lr;
      adcseq_pkg::IDX_SAMPLE_TIME_MISC: v = s.regs.sample_time_misc;
      adcseq_pkg::IDX_MISC_CAP_LEN_LOW: v = s.regs.misc_capture_len_low;
      adcseq_pkg::IDX_LR_CAP_LEN_LOW: v = s.regs.lr_capture_len_low;
      adcseq_pkg::IDX_STATE_LEN_HIGH: v = s.regs.state_length_high;
      adcseq_pkg::IDX_CHAN_EN_LAST: v = s.regs.channel_enable_last_index;
      adcseq_pkg::IDX_CONV_CLK_DIV: v = s.regs.converter_clock_divider;
      adcseq_pkg::IDX_MISC_RESULT_LOW: v = s.result_misc[7:0];
      adcseq_pkg::IDX_MISC_RESULT_HIGH: v = {s.valid_flag, s.result_misc[14:8]};
      adcseq_pkg::IDX_INPUT_SCALING: v = s.regs.input_scaling;
      adcseq_pkg::IDX_CONVERTER_POWER: v = s.regs.converter_power;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // =====================================================================
  // State and working signals
  adcseq_pkg::adcseq_state_t q; // Registered state
  adcseq_pkg::adcseq_state_t d; // Next state
  logic req; // Bus request present
  logic [adcseq_pkg::IDX_W-1:0] widx; // Word index of the access
  logic [8:0] acc_sum; // Phase accumulator sum
  logic ref_tick; // One pulse per 24 MHz reference cycle
  logic [2:0] en_eff; // Effective channel enables
  logic [2:0] last_idx; // Programmed last state index
  logic [9:0] len; // Length of the current state
  logic state_end; // Current state finishes this cycle
  logic do_enter; // Enter a new state this cycle
  logic [2:0] nidx; // Index being entered
  logic [2:0] look; // Slot lookup result
  logic [14:0] cap_data; // Sign-extended capture

  // Handshake is combinational: stall only the first cycle of a request
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~q.ack;
  assign avs_readdata_o = q.rdata;
  assign conv_ctrl_o = q.ctrl;
  assign sample_o = q.sample;
  assign widx = avs_address_i[adcseq_pkg::ADDR_W-1:2];

  // =====================================================================
  // Next-state logic
  always_comb begin
    d = q;
    d.ctrl.run = 1'b0;
    d.ctrl.clk_en = 1'b0;
    d.sample.valid = 1'b0;
    do_enter = 1'b0;
    nidx = 3'h1;
    look = 3'h0;
    cap_data = sext(conv_data_i, q.ctrl.res);

    // Bus: first cycle samples read data, second cycle answers
    d.ack = req & ~q.ack;
    if (avs_read_i && !q.ack) begin
      d.rdata = {24'h000000, read_reg(widx, q)};
    end
    // Writes land at the answering edge, low byte lane only
    if (avs_write_i && q.ack && avs_byteenable_i[0]) begin
      unique case (widx)
        adcseq_pkg::IDX_VREF_SELECT: d.regs.vref_select = avs_writedata_i[7:0];
        adcseq_pkg::IDX_RESOLUTION_SELECT: d.regs.resolution_select = avs_writedata_i[7:0];
        adcseq_pkg::IDX_DIFF_MISC_RES: d.regs.diff_and_misc_resolution = avs_writedata_i[7:0];
        adcseq_pkg::IDX_SAMPLE_TIME_LR: d.regs.sample_time_lr = avs_writedata_i[7:0];
        adcseq_pkg::IDX_SAMPLE_TIME_MISC: d.regs.sample_time_misc = avs_writedata_i[7:0];
        adcseq_pkg::IDX_MISC_CAP_LEN_LOW: d.regs.misc_capture_len_low = avs_writedata_i[7:0];
        adcseq_pkg::IDX_LR_CAP_LEN_LOW: d.regs.lr_capture_len_low = avs_writedata_i[7:0];
        adcseq_pkg::IDX_STATE_LEN_HIGH: d.regs.state_length_high = avs_writedata_i[7:0];
        adcseq_pkg::IDX_CHAN_EN_LAST: d.regs.channel_enable_last_index = avs_writedata_i[7:0];
        adcseq_pkg::IDX_CONV_CLK_DIV: d.regs.converter_clock_divider = avs_writedata_i[7:0];
        adcseq_pkg::IDX_INPUT_SCALING: d.regs.input_scaling = avs_writedata_i[7:0];
        adcseq_pkg::IDX_CONVERTER_POWER: d.regs.converter_power = avs_writedata_i[7:0];
        default: begin
          // Read-only or unmapped: write is accepted and dropped
        end
      endcase
    end

    // Power level follows the register directly
    d.ctrl.power_down = q.regs.converter_power[adcseq_pkg::POWER_DOWN_BIT];

    // Fractional divider: 24 pulses in every 125 clocks, jitter of one clock
    acc_sum = {1'b0, q.ref_acc} + {1'b0, adcseq_pkg::REF_STEP};
    ref_tick = (acc_sum >= {1'b0, adcseq_pkg::REF_MOD});
    if (ref_tick) begin
      d.ref_acc = 8'(acc_sum - {1'b0, adcseq_pkg::REF_MOD});
    end else begin
      d.ref_acc = acc_sum[7:0];
    end

    // Converter clock enable every divider+1 reference ticks
    if (ref_tick) begin
      if (q.div_cnt == q.regs.converter_clock_divider[2:0]) begin
        d.div_cnt = 3'h0;
        d.ctrl.clk_en = 1'b1;
      end else begin
        d.div_cnt = q.div_cnt + 3'h1;
      end
    end

    // Right counts only behind left; left and misc stand alone
    en_eff[adcseq_pkg::EN_LEFT_BIT] = q.regs.channel_enable_last_index[adcseq_pkg::EN_LEFT_BIT];
    en_eff[adcseq_pkg::EN_RIGHT_BIT] = q.regs.channel_enable_last_index[adcseq_pkg::EN_RIGHT_BIT]
      & q.regs.channel_enable_last_index[adcseq_pkg::EN_LEFT_BIT];
    en_eff[adcseq_pkg::EN_MISC_BIT] = q.regs.channel_enable_last_index[adcseq_pkg::EN_MISC_BIT];
    last_idx = q.regs.channel_enable_last_index[adcseq_pkg::LAST_IDX_LSB +: 3];

    // Length of the running state in reference ticks
    if (q.st == adcseq_pkg::SQ_SET) begin
      len = {6'h00, q.regs.state_length_high[adcseq_pkg::SET_LEN_LSB +: 4]};
    end else if (q.chan == adcseq_pkg::CH_MISC) begin
      len = {q.regs.state_length_high[adcseq_pkg::MISC_CAP_HI_LSB +: 2],
             q.regs.misc_capture_len_low};
    end else begin
      len = {q.regs.state_length_high[adcseq_pkg::LR_CAP_HI_LSB +: 2],
             q.regs.lr_capture_len_low};
    end
    // A zero length still takes one tick so the walk never stalls
    state_end = ref_tick && ({1'b0, q.cnt} + 11'h001 >= {1'b0, len});

    // Sequencer walk
    if (q.regs.converter_power[adcseq_pkg::POWER_DOWN_BIT] || en_eff == 3'h0) begin
      // Powered down or nothing enabled: park
      d.st = adcseq_pkg::SQ_IDLE;
      d.idx = 3'h0;
      d.cnt = 10'h000;
    end else begin
      unique case (q.st)
        adcseq_pkg::SQ_IDLE: begin
          do_enter = 1'b1;
          nidx = 3'h1;
        end
        adcseq_pkg::SQ_SET,
        adcseq_pkg::SQ_CAPTURE: begin
          if (state_end) begin
            do_enter = 1'b1;
            // Wrap after the programmed last index
            if (q.idx == last_idx || q.idx == 3'h7) begin
              nidx = 3'h1;
            end else begin
              nidx = q.idx + 3'h1;
            end
          end else if (ref_tick) begin
            d.cnt = q.cnt + 10'h001;
          end
        end
        default: begin
          // Illegal phase code: restart cleanly
          do_enter = 1'b1;
          nidx = 3'h1;
        end
      endcase
    end

    if (do_enter) begin
      // Odd index is Set, even is Capture of slot (index-1)/2
      look = slot_chan(2'((nidx - 3'h1) >> 1), en_eff);
      if (!look[2]) begin
        // Index past the enabled channels: begin again
        nidx = 3'h1;
        look = slot_chan(2'h0, en_eff);
      end
      d.idx = nidx;
      d.cnt = 10'h000;
      d.chan = adcseq_pkg::adcseq_chan_e_t'(look[1:0]);
      if (nidx[0]) begin
        d.st = adcseq_pkg::SQ_SET;
        d.ctrl = chan_settings(q.regs, adcseq_pkg::adcseq_chan_e_t'(look[1:0]));
        d.ctrl.clk_en = 1'b0;
        if (ref_tick && q.div_cnt == q.regs.converter_clock_divider[2:0]) begin
          d.ctrl.clk_en = 1'b1;
        end
      end else begin
        d.st = adcseq_pkg::SQ_CAPTURE;
        d.ctrl.run = 1'b1;
        d.valid_flag = 1'b0;
      end
    end

    // Capture end latches data; placed last so the set beats any clear
    if (q.st == adcseq_pkg::SQ_CAPTURE && state_end && do_enter) begin
      d.sample.valid = 1'b1;
      d.sample.chan = q.chan;
      d.sample.data = cap_data;
      d.valid_flag = 1'b1;
      if (q.chan == adcseq_pkg::CH_MISC) begin
        d.result_misc = cap_data;
      end
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.regs.converter_power <= adcseq_pkg::POWER_RST;
      q.ctrl.power_down <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule // adcseq_sequencer

// ==== testbench/adcseq_sequencer_chk.sv ====
`timescale 1ns/10ps
// ==========
// Port checks of the sequencer
module adcseq_sequencer_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [adcseq_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire adcseq_pkg::adcseq_conv_ctrl_t conv_ctrl_o,
  input wire adcseq_pkg::adcseq_sample_t sample_o
);
  adcseq_pkg::adcseq_chan_e_t run_chan_q; // Channel of latest run
  logic [3:0] since_run_q; // Saturates so it never wraps
  // Track the conversion in flight
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_chan_q <= adcseq_pkg::CH_LEFT;
      since_run_q <= 4'hF;
    end else if (conv_ctrl_o.run) begin
      run_chan_q <= conv_ctrl_o.chan;
      since_run_q <= 4'h0;
    end else if (since_run_q != 4'hF) begin
      since_run_q <= since_run_q + 4'h1;
    end
  end
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // Assertions
  pwr_no_run_a: assert property (conv_ctrl_o.power_down |-> !conv_ctrl_o.run)
    else $error("run while powered down");
  wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait state");
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait state too long");
  rdata_upper_a: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("upper read data set");
  run_pulse_a: assert property (conv_ctrl_o.run |=> !conv_ctrl_o.run)
    else $error("run longer than one cycle");
  valid_pulse_a: assert property (sample_o.valid |=> !sample_o.valid)
    else $error("valid longer than one cycle");
  capture_hold_a: assert property (conv_ctrl_o.run |=> $stable(conv_ctrl_o[12:0]) [*3])
    else $error("settings moved in capture");
  sample_chan_a: assert property (sample_o.valid |-> sample_o.chan == run_chan_q)
    else $error("result channel mismatch");
  capture_min_a: assert property (sample_o.valid |-> since_run_q >= 4'h4)
    else $error("capture shorter than a tick");
  clk_en_gap_a: assert property (conv_ctrl_o.clk_en |=> !conv_ctrl_o.clk_en [*3])
    else $error("converter clock too fast");
  // Main scenarios reached
  cover property (conv_ctrl_o.run);
  cover property (sample_o.valid && sample_o.chan == adcseq_pkg::CH_MISC);
  cover property (avs_read_i && !avs_waitrequest_o);
endmodule // adcseq_sequencer_chk

bind adcseq_sequencer adcseq_sequencer_chk chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .conv_ctrl_o(conv_ctrl_o), .sample_o(sample_o));

// ==== testbench/adcseq_conv_model.sv ====
`timescale 1ns/10ps
// ==========
// Converter core stand-in
module adcseq_conv_model #(
  parameter logic [13:0] RAW_L = 14'h0000, // Left answer
  parameter logic [13:0] RAW_R = 14'h0000, // Right answer
  parameter logic [13:0] RAW_M = 14'h0000 // Misc answer
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire adcseq_pkg::adcseq_conv_ctrl_t ctrl_i,
  output logic [13:0] data_o
);
  int pend; // Converter clocks until settled
  // Output toggles while unsettled, so an early capture shows garbage
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend <= 0;
      data_o <= 14'h0000;
    end else if (ctrl_i.run) begin
      pend <= int'(ctrl_i.tsamp) + 4;
      data_o <= ~data_o;
    end else if (pend != 0) begin
      pend <= pend - int'(ctrl_i.clk_en);
      data_o <= (pend == 1 && ctrl_i.clk_en) ? (ctrl_i.chan == 2'd0 ? RAW_L :
        (ctrl_i.chan == 2'd1 ? RAW_R : RAW_M)) : ~data_o;
    end
  end
endmodule // adcseq_conv_model

// ==== testbench/test_adcseq_sequencer.sv ====
`timescale 1ns/10ps
// ==========
// Self-checking bench of the sequencer
module test_adcseq_sequencer;
  localparam logic [13:0] RAW [0:2] = '{14'h2255, 14'h125C, 14'h3F81}; // Converter answers
  localparam logic [1:0] RES [0:2] = '{2'd1, 2'd2, 2'd3}; // Resolution per channel
  localparam logic [10:0] SET [0:2] = '{11'h0C5, 11'h349, 11'h5CD}; // Expected settings
  localparam logic [9:0] REGS [0:14] = '{10'h0E7, 10'h0EB, 10'h0EC, 10'h0ED, 10'h0EE, 10'h0EF, 10'h0F0,
    10'h0F1, 10'h0F2, 10'h0F4, 10'h0F7, 10'h0F8, 10'h0FA, 10'h0FC, 10'h3FF};
  localparam logic [7:0] CFG [0:9] = '{8'h24, 8'h21, 8'h73, 8'h21, 8'h03, 8'h04, 8'h14, 8'h43, 8'h00, 8'h01};
  localparam logic [7:0] MODE [0:5] = '{8'h67, 8'h45, 8'h43, 8'h21, 8'h24, 8'h22}; // Enables and last index
  localparam int TICKS [0:5] = '{309, 286, 46, 23, 263, 0}; // Period in reference ticks
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [11:0] avs_address_i = 12'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [13:0] conv_data_i;
  adcseq_pkg::adcseq_conv_ctrl_t conv_ctrl_o;
  adcseq_pkg::adcseq_sample_t sample_o;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_run = 0;
  int n_smp = 0;
  int per [0:2]; // Spacing of latest results
  int last_t [0:2]; // Cycle of latest result
  logic [2:0] cur_en = 3'h0; // Enables of the running mode
  logic [1:0] prev = 2'd2; // Channel of the latest result

  adcseq_sequencer dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .conv_data_i(conv_data_i), .conv_ctrl_o(conv_ctrl_o), .sample_o(sample_o));
  adcseq_conv_model #(.RAW_L(RAW[0]), .RAW_R(RAW[1]), .RAW_M(RAW[2])) core_u (.clk_i(clk_i),
    .resetn_i(resetn_i), .ctrl_i(conv_ctrl_o), .data_o(conv_data_i));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ==========
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [14:0] sext(input logic [13:0] raw, input logic [1:0] res);
    logic [14:0] v;
    v = {1'b0, raw};
    for (int b = 8 + 2 * res; b < 15; b++) v[b] = raw[7 + 2 * res];
    return v;
  endfunction

  // Next channel that the walk visits; right counts only beside left
  function automatic logic [1:0] nxt(input logic [2:0] en, input logic [1:0] ch);
    logic [1:0] c;
    c = ch;
    for (int k = 0; k < 3; k++) begin
      c = (c == 2'd2) ? 2'd0 : c + 2'd1;
      if (en[c] && (c != 2'd1 || en[0])) return c;
    end
    return c;
  endfunction

  // One Avalon cycle; waitrequest and read data are taken at the rising edge itself
  // Only the watchdog ends a wait that never answers
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    logic w;
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h000000, wd};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      w = avs_waitrequest_o;
      rd = avs_readdata_o[7:0];
    end while (w !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    check(32'(x), 32'(exp));
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watch results and conversion starts
  always @(posedge clk_i) begin
    cyc++;
    if (conv_ctrl_o.run === 1'b1) begin
      n_run++;
      check(32'(conv_ctrl_o[10:0]), 32'(SET[conv_ctrl_o.chan]));
    end
    if (sample_o.valid === 1'b1) begin
      check(32'(sample_o.chan), 32'(nxt(cur_en, prev)));
      check(32'(sample_o.data), 32'(sext(RAW[sample_o.chan], RES[sample_o.chan])));
      prev = sample_o.chan;
      per[sample_o.chan] = cyc - last_t[sample_o.chan];
      last_t[sample_o.chan] = cyc;
      n_smp++;
    end
  end

  // Hang guard, well beyond the expected run
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  // ==========
  // Test sequence
  initial begin
    int k;
    logic [14:0] e;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 15; i++) rdchk(REGS[i], i == 13 ? 8'h20 : 8'h00);
    for (int i = 0; i < 15; i++) wr(REGS[i], 8'hA0 + 8'(i));
    for (int i = 0; i < 15; i++) rdchk(REGS[i], (i == 10 || i == 11 || i == 14) ? 8'h00 : 8'hA0 + 8'(i));
    avs_byteenable_i <= 4'h0;
    wr(10'h0F0, 8'h11);
    avs_byteenable_i <= 4'hF;
    rdchk(10'h0F0, 8'hA6);
    for (int i = 0; i < 10; i++) wr(REGS[i], CFG[i]);
    wr(10'h0FA, 8'h40);
    for (int m = 0; m < 6; m++) begin
      wr(10'h0F2, MODE[m]);
      cur_en = MODE[m][2:0];
      prev = 2'd2;
      n_run = 0;
      n_smp = 0;
      repeat (300) @(posedge clk_i);
      check(32'(n_run), 32'h0);
      wr(10'h0FC, 8'h00);
      repeat (TICKS[m] * 24 + 300) @(posedge clk_i);
      check(32'(n_smp != 0), 32'(m != 5));
      for (int c = 0; c < 3; c++) begin
        if (MODE[m][c] && (c != 1 || MODE[m][0])) check(32'(per[c] * 24 - TICKS[m] * 125 + 125 <= 250), 32'h1);
      end
      if (MODE[m][2]) begin
        k = 0;
        while ((sample_o.valid !== 1'b1 || sample_o.chan !== 2'd2) && k++ < 5000) @(negedge clk_i);
        @(posedge clk_i);
        e = sext(RAW[2], 2'd3);
        rdchk(10'h0F8, {1'b1, e[14:8]});
        rdchk(10'h0F7, e[7:0]);
        repeat (30) @(posedge clk_i);
        rdchk(10'h0F8, {1'b0, e[14:8]});
      end
      wr(10'h0FC, 8'h20);
      repeat (20) @(posedge clk_i);
    end
    give_verdict();
  end
endmodule // test_adcseq_sequencer
